// [core/acsf_pkg.sv]
// acsf_pkg: constants, register map and field layout of the sample queue.
// assumes one 8-bit register address space shared with the rest of the device.
package acsf_pkg;

    // register addresses
    localparam logic [7:0] ACSF_ADDR_X0 = 8'h32;
    localparam logic [7:0] ACSF_ADDR_X1 = 8'h33;
    localparam logic [7:0] ACSF_ADDR_Y0 = 8'h34;
    localparam logic [7:0] ACSF_ADDR_Y1 = 8'h35;
    localparam logic [7:0] ACSF_ADDR_Z0 = 8'h36;
    localparam logic [7:0] ACSF_ADDR_Z1 = 8'h37;
    localparam logic [7:0] ACSF_ADDR_CTRL = 8'h38;
    localparam logic [7:0] ACSF_ADDR_STAT = 8'h39;

    // storage geometry
    localparam int ACSF_DEPTH = 32;
    localparam int ACSF_PTR_W = 5;
    localparam int ACSF_CNT_W = 6;
    localparam int ACSF_AXIS_W = 16;
    localparam int ACSF_ENTRY_W = 48;
    localparam logic [5:0] ACSF_FULL_CNT = 6'h20;
    localparam logic [5:0] ACSF_EMPTY_CNT = 6'h00;

    // queue_control fields
    localparam int ACSF_MODE_HI = 7;
    localparam int ACSF_MODE_LO = 6;
    localparam int ACSF_TRIG_SRC_BIT = 5;
    localparam int ACSF_WM_HI = 4;
    localparam int ACSF_WM_LO = 0;
    localparam logic [7:0] ACSF_CTRL_RESET = 8'h00;
    localparam logic [4:0] ACSF_WM_ZERO = 5'h00;

    // queue_state fields
    localparam int ACSF_STAT_TRIG_BIT = 7;
    localparam int ACSF_STAT_CNT_HI = 5;

    // queue modes
    localparam logic [1:0] ACSF_MODE_BYPASS = 2'h0;
    localparam logic [1:0] ACSF_MODE_COLLECT = 2'h1;
    localparam logic [1:0] ACSF_MODE_STREAM = 2'h2;
    localparam logic [1:0] ACSF_MODE_TRIGGER = 2'h3;

    // true for any of the six axis sample bytes
    function automatic logic acsf_is_axis(input logic [7:0] addr);
        acsf_is_axis = (addr >= ACSF_ADDR_X0) && (addr <= ACSF_ADDR_Z1);
    endfunction : acsf_is_axis

endpackage : acsf_pkg

// [core/acsf_store.sv]
// acsf_store: 32-entry circular store of three-axis samples.
// assumes the caller never pushes when full without popping in the same cycle.
`timescale 1ns/10ps
module acsf_store
    import acsf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic push,
    input wire logic pop,
    input wire logic flush,
    input wire logic [ACSF_ENTRY_W-1:0] push_data,
    output logic [ACSF_ENTRY_W-1:0] head_data,
    output logic [ACSF_CNT_W-1:0] count
);

    logic [ACSF_ENTRY_W-1:0] mem [0:ACSF_DEPTH-1];
    logic [ACSF_PTR_W-1:0] wr_ptr_reg;
    logic [ACSF_PTR_W-1:0] wr_ptr_next;
    logic [ACSF_PTR_W-1:0] rd_ptr_reg;
    logic [ACSF_PTR_W-1:0] rd_ptr_next;
    logic [ACSF_CNT_W-1:0] count_reg;
    logic [ACSF_CNT_W-1:0] count_next;

    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (flush)
        begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            count_next = ACSF_EMPTY_CNT;
        end
        else
        begin
            if (push)
                wr_ptr_next = wr_ptr_reg + ACSF_PTR_W'(1);
            if (pop)
                rd_ptr_next = rd_ptr_reg + ACSF_PTR_W'(1);
            if (push && !pop)
                count_next = count_reg + ACSF_CNT_W'(1);
            else if (pop && !push)
                count_next = count_reg - ACSF_CNT_W'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= ACSF_EMPTY_CNT;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // no reset on the array: contents are only read behind a nonzero count
    always_ff @(posedge clock)
    begin
        if (push && !flush)
            mem[wr_ptr_reg] <= push_data;
    end

    assign head_data = mem[rd_ptr_reg];
    assign count = count_reg;

endmodule : acsf_store

// [core/acsf_queue.sv]
// acsf_queue: sample queue with bypass, collect, stream and trigger modes,
// an output entry ahead of the store, status flags and register access.
// assumes samples, interrupt pins and register strobes all come from logic on clock.
`timescale 1ns/10ps
// Functional notes
// - mode field bits 7:6 of queue_control: bypass, collect, stream, trigger.
// - collect mode stores until 32 held, then stores only when not full.
// - stream mode keeps latest 32; a new sample displaces the oldest.
// - trigger mode keeps recent samples, then after trigger stores until full.
// - trigger source bit picks first irq pin at 0, second at 1.
// - writing watermark level 0 sets the watermark flag at once, any mode.
// - collect and stream: level is watermark threshold; bypass ignores it.
// - trigger mode: level is number of samples kept before trigger.
// - queue_state bit 7 reads 1 once a trigger event has occurred.
// - queue_state bits 5:0 report the number of stored samples.
// - any axis register read transaction removes one level.
// - at most 32 stored plus one output entry, 33 available.
// - data ready, watermark, overrun flags stay set until an axis read clears them.
// - no samples are stored while sleep mode is on.
module acsf_queue
    import acsf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sample_valid,
    input wire logic [ACSF_AXIS_W-1:0] sample_x,
    input wire logic [ACSF_AXIS_W-1:0] sample_y,
    input wire logic [ACSF_AXIS_W-1:0] sample_z,
    input wire logic sleep_mode,
    input wire logic first_irq_pin,
    input wire logic second_irq_pin,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_stb,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_stb,
    input wire logic xfer_done,
    output logic [7:0] reg_rd_data,
    output logic data_ready_flag,
    output logic watermark_flag,
    output logic overrun_flag,
    output logic capture_event_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [ACSF_ENTRY_W-1:0] out_data_reg;
    logic [ACSF_ENTRY_W-1:0] out_data_next;
    logic out_valid_reg;
    logic out_valid_next;
    logic trig_reg;
    logic trig_next;
    logic pin_prev_reg;
    logic pin_prev_next;
    logic touched_reg;
    logic touched_next;
    logic dr_reg;
    logic dr_next;
    logic wm_reg;
    logic wm_next;
    logic ovr_reg;
    logic ovr_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    logic st_push;
    logic st_pop;
    logic st_flush;
    logic [ACSF_ENTRY_W-1:0] st_head;
    logic [ACSF_CNT_W-1:0] st_count;

    logic [1:0] mode;
    logic [ACSF_CNT_W-1:0] wm_level;
    logic trig_pin;
    logic ctrl_wr;
    logic axis_pop;
    logic smp;
    logic [ACSF_ENTRY_W-1:0] smp_data;
    logic [ACSF_CNT_W-1:0] shown_count;

    ////////////////////////////////////////////////////////////////////////////
    // store

    acsf_store u_store (
        .clock(clock),
        .rst_b(rst_b),
        .push(st_push),
        .pop(st_pop),
        .flush(st_flush),
        .push_data(smp_data),
        .head_data(st_head),
        .count(st_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    assign mode = ctrl_reg[ACSF_MODE_HI:ACSF_MODE_LO];
    assign wm_level = {1'b0, ctrl_reg[ACSF_WM_HI:ACSF_WM_LO]};
    assign trig_pin = ctrl_reg[ACSF_TRIG_SRC_BIT] ? second_irq_pin : first_irq_pin;
    assign ctrl_wr = reg_wr_stb && (reg_addr == ACSF_ADDR_CTRL);
    // one level per transaction, so a burst sees one stable sample except in bypass, where a new sample overwrites the output entry at once
    assign axis_pop = xfer_done && (touched_reg || (reg_rd_stb && acsf_is_axis(reg_addr)));
    assign smp = sample_valid && !sleep_mode;
    assign smp_data = {sample_z, sample_y, sample_x};
    assign shown_count = (mode == ACSF_MODE_BYPASS) ? ACSF_EMPTY_CNT : st_count;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic out_free;
        logic pop_used;
        logic wm_hit;
        out_free = 1'b0;
        pop_used = 1'b0;
        wm_hit = 1'b0;
        ctrl_next = ctrl_reg;
        out_data_next = out_data_reg;
        out_valid_next = out_valid_reg;
        trig_next = trig_reg;
        pin_prev_next = trig_pin;
        touched_next = touched_reg;
        dr_next = dr_reg;
        wm_next = wm_reg;
        ovr_next = ovr_reg;
        st_push = 1'b0;
        st_pop = 1'b0;
        st_flush = 1'b0;

        // host side: transaction tracking and control writes
        if (xfer_done)
            touched_next = 1'b0;
        else if (reg_rd_stb && acsf_is_axis(reg_addr))
            touched_next = 1'b1;
        if (ctrl_wr)
        begin
            ctrl_next = reg_wr_data;
            trig_next = 1'b0;
            if (reg_wr_data[ACSF_MODE_HI:ACSF_MODE_LO] == ACSF_MODE_BYPASS)
                st_flush = 1'b1;
        end

        // clears first; any set below wins over them
        if (axis_pop)
        begin
            dr_next = 1'b0;
            wm_next = 1'b0;
            ovr_next = 1'b0;
        end

        if (mode == ACSF_MODE_BYPASS)
        begin
            if (axis_pop)
                out_valid_next = 1'b0;
            if (smp)
            begin
                if (out_valid_reg && !axis_pop)
                    ovr_next = 1'b1;
                out_data_next = smp_data;
                out_valid_next = 1'b1;
                dr_next = 1'b1;
            end
        end
        else if (!st_flush)
        begin
            // drain: output entry refills from the store head
            if (axis_pop && out_valid_reg)
            begin
                if (st_count != ACSF_EMPTY_CNT)
                begin
                    out_data_next = st_head;
                    st_pop = 1'b1;
                    pop_used = 1'b1;
                end
                else
                    out_valid_next = 1'b0;
            end
            out_free = !out_valid_reg || (axis_pop && st_count == ACSF_EMPTY_CNT);
            if (smp)
            begin
                dr_next = 1'b1;
                if (out_free && st_count == ACSF_EMPTY_CNT)
                begin
                    out_data_next = smp_data;
                    out_valid_next = 1'b1;
                end
                else if (mode == ACSF_MODE_TRIGGER && !trig_reg && !pop_used
                         && st_count >= wm_level)
                begin
                    st_pop = 1'b1;
                    st_push = 1'b1;
                end
                else if (st_count < ACSF_FULL_CNT || pop_used)
                    st_push = 1'b1;
                else if (mode == ACSF_MODE_STREAM)
                begin
                    st_pop = 1'b1;
                    st_push = 1'b1;
                    ovr_next = 1'b1;
                end
                else
                    ovr_next = 1'b1;
            end
        end

        // trigger capture on a rising edge of the selected pin
        if (mode == ACSF_MODE_TRIGGER && !ctrl_wr && !trig_reg && trig_pin && !pin_prev_reg)
            trig_next = 1'b1;

        // watermark: threshold only in collect and stream
        if (mode == ACSF_MODE_COLLECT || mode == ACSF_MODE_STREAM)
            wm_hit = (st_count >= wm_level);
        if (wm_hit && !ctrl_wr)
            wm_next = 1'b1;
        if (ctrl_wr && reg_wr_data[ACSF_WM_HI:ACSF_WM_LO] == ACSF_WM_ZERO)
            wm_next = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read

    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (reg_rd_stb)
        begin
            unique case (reg_addr)
                ACSF_ADDR_X0: rd_data_next = out_data_reg[7:0];
                ACSF_ADDR_X1: rd_data_next = out_data_reg[15:8];
                ACSF_ADDR_Y0: rd_data_next = out_data_reg[23:16];
                ACSF_ADDR_Y1: rd_data_next = out_data_reg[31:24];
                ACSF_ADDR_Z0: rd_data_next = out_data_reg[39:32];
                ACSF_ADDR_Z1: rd_data_next = out_data_reg[47:40];
                ACSF_ADDR_CTRL: rd_data_next = ctrl_reg;
                ACSF_ADDR_STAT:
                begin
                    rd_data_next = '0;
                    rd_data_next[ACSF_STAT_TRIG_BIT] = trig_reg;
                    rd_data_next[ACSF_STAT_CNT_HI:0] = shown_count;
                end
                default: rd_data_next = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ctrl_reg <= ACSF_CTRL_RESET;
            out_data_reg <= '0;
            out_valid_reg <= 1'b0;
            trig_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
            touched_reg <= 1'b0;
            dr_reg <= 1'b0;
            wm_reg <= 1'b0;
            ovr_reg <= 1'b0;
            rd_data_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            out_data_reg <= out_data_next;
            out_valid_reg <= out_valid_next;
            trig_reg <= trig_next;
            pin_prev_reg <= pin_prev_next;
            touched_reg <= touched_next;
            dr_reg <= dr_next;
            wm_reg <= wm_next;
            ovr_reg <= ovr_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign data_ready_flag = dr_reg;
    assign watermark_flag = wm_reg;
    assign overrun_flag = ovr_reg;
    assign capture_event_flag = trig_reg;

endmodule : acsf_queue

// [tb/acsf_host.sv]
// acsf_host: host model issuing register strobes to the sample queue.
// assumes strobes are sampled on the rising edge of clock.
`timescale 1ns/10ps
module acsf_host (
    input logic clock,
    output logic [7:0] reg_addr,
    output logic reg_wr_stb,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_stb,
    output logic xfer_done
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr_stb = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_stb = 1'b0;
        xfer_done = 1'b0;
    end

    // one transaction of n bytes; a burst ends with xfer_done on its last strobe
    task automatic xfer(input logic [7:0] a, input int n, input logic w, input logic [7:0] d);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clock);
            reg_addr = a + 8'(i);
            reg_wr_stb = w;
            reg_wr_data = d;
            reg_rd_stb = !w;
            xfer_done = (i == n - 1);
        end
        @(negedge clock);
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        xfer_done = 1'b0;
        // released lines must not keep the last value
        reg_addr = ~reg_addr;
        reg_wr_data = ~reg_wr_data;
    endtask : xfer
endmodule : acsf_host

// [tb/acsf_queue_properties.sv]
// acsf_queue_props: port-level checks of the sample queue.
// assumes it is bound to acsf_queue and sees only its ports.
`timescale 1ns/10ps
module acsf_queue_props
    import acsf_pkg::*;
(
    input logic clock,
    input logic rst_b,
    input logic sample_valid,
    input logic [ACSF_AXIS_W-1:0] sample_x,
    input logic [ACSF_AXIS_W-1:0] sample_y,
    input logic [ACSF_AXIS_W-1:0] sample_z,
    input logic sleep_mode,
    input logic first_irq_pin,
    input logic second_irq_pin,
    input logic [7:0] reg_addr,
    input logic reg_wr_stb,
    input logic [7:0] reg_wr_data,
    input logic reg_rd_stb,
    input logic xfer_done,
    input logic [7:0] reg_rd_data,
    input logic data_ready_flag,
    input logic watermark_flag,
    input logic overrun_flag,
    input logic capture_event_flag
);
    logic [7:0] ctl_reg;
    logic axis_reg;
    logic ctl_wr;
    logic st_rd;
    assign ctl_wr = reg_wr_stb && reg_addr == ACSF_ADDR_CTRL;
    assign st_rd = reg_rd_stb && reg_addr == ACSF_ADDR_STAT;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            ctl_reg <= ACSF_CTRL_RESET;
        else if (ctl_wr)
            ctl_reg <= reg_wr_data;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b || xfer_done)
            axis_reg <= 1'b0;
        else if (reg_rd_stb && acsf_is_axis(reg_addr))
            axis_reg <= 1'b1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////
    ctl_rdback_a: assert property (reg_rd_stb && reg_addr == ACSF_ADDR_CTRL |=>
        reg_rd_data == $past(ctl_reg)) else $error("queue_control readback wrong");
    stat_fields_a: assert property (st_rd |=> !reg_rd_data[6] &&
        reg_rd_data[5:0] <= ACSF_FULL_CNT) else $error("queue_state field out of range");
    trig_bit_a: assert property (st_rd |=> reg_rd_data[7] == $past(capture_event_flag))
        else $error("queue_state bit 7 differs from capture flag");
    bypass_cnt_a: assert property (st_rd && ctl_reg[7:6] == ACSF_MODE_BYPASS |=>
        reg_rd_data[5:0] == 6'h00) else $error("bypass count not zero");
    wm_zero_a: assert property (ctl_wr && reg_wr_data[4:0] == ACSF_WM_ZERO |->
        ##[1:2] watermark_flag) else $error("watermark not set by level zero");
    trig_clear_a: assert property (ctl_wr |=> !capture_event_flag)
        else $error("capture flag kept over control write");
    trig_src_a: assert property ($rose(capture_event_flag) |->
        ctl_reg[7:6] == ACSF_MODE_TRIGGER && (ctl_reg[5] ? $past(second_irq_pin) :
        $past(first_irq_pin))) else $error("capture flag without selected pin");
    ready_cause_a: assert property ($rose(data_ready_flag) |->
        $past(sample_valid) && !$past(sleep_mode)) else $error("data ready without sample");
    ovr_cause_a: assert property ($rose(overrun_flag) |->
        $past(sample_valid) && !$past(sleep_mode)) else $error("overrun without sample");
    flag_clr_a: assert property (xfer_done && !sample_valid && (axis_reg || reg_rd_stb &&
        acsf_is_axis(reg_addr)) |=> !data_ready_flag && !overrun_flag)
        else $error("flags not cleared by axis read");
    rd_hold_a: assert property (!reg_rd_stb |=> $stable(reg_rd_data))
        else $error("read data changed without a read");

    full_c: cover property (st_rd ##1 reg_rd_data[5:0] == ACSF_FULL_CNT);
    trig_c: cover property ($rose(capture_event_flag));
    ovr_c: cover property ($rose(overrun_flag));
endmodule : acsf_queue_props

bind acsf_queue acsf_queue_props u_props (.clock(clock), .rst_b(rst_b),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z), .sleep_mode(sleep_mode), .first_irq_pin(first_irq_pin),
    .second_irq_pin(second_irq_pin), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
    .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb), .xfer_done(xfer_done),
    .reg_rd_data(reg_rd_data), .data_ready_flag(data_ready_flag),
    .watermark_flag(watermark_flag), .overrun_flag(overrun_flag),
    .capture_event_flag(capture_event_flag));

// [tb/tb_acsf_queue.sv]
// tb_acsf_queue: self-checking bench of the sample queue in all four modes.
// assumes acsf_host as register master and acsf_queue_props bound to the design.
`timescale 1ns/10ps
module tb_acsf_queue
    import acsf_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic sample_valid = 1'b0;
    logic [15:0] sample_x = 16'h0000;
    logic [15:0] sample_y = 16'h0000;
    logic [15:0] sample_z = 16'h0000;
    logic sleep_mode = 1'b0;
    logic first_irq_pin = 1'b0;
    logic second_irq_pin = 1'b0;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic reg_wr_stb, reg_rd_stb, xfer_done;
    logic data_ready_flag, watermark_flag, overrun_flag, capture_event_flag;
    logic [47:0] sent[$];
    logic [7:0] expq[$];
    int n_errors = 0;
    int compares = 0;

    initial
    begin
        forever #10 clock = ~clock;
    end

    acsf_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
        .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb), .xfer_done(xfer_done));
    acsf_queue uut (.clock(clock), .rst_b(rst_b), .sample_valid(sample_valid),
        .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
        .sleep_mode(sleep_mode), .first_irq_pin(first_irq_pin),
        .second_irq_pin(second_irq_pin), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
        .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb), .xfer_done(xfer_done),
        .reg_rd_data(reg_rd_data), .data_ready_flag(data_ready_flag),
        .watermark_flag(watermark_flag), .overrun_flag(overrun_flag),
        .capture_event_flag(capture_event_flag));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // read data is settled half a cycle after the strobe edge
    initial
    begin
        forever
        begin
            @(posedge clock);
            if (reg_rd_stb === 1'b1)
            begin
                @(negedge clock);
                chk("reg_rd_data", expq.pop_front(), reg_rd_data);
            end
        end
    end

    task automatic wr(input logic [7:0] d);
        host.xfer(ACSF_ADDR_CTRL, 1, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        host.xfer(a, 1, 1'b0, 8'h00);
    endtask : rd

    task automatic burst(input int i);
        for (int k = 0; k < 6; k++)
            expq.push_back(sent[i][8*k +: 8]);
        host.xfer(ACSF_ADDR_X0, 6, 1'b0, 8'h00);
    endtask : burst

    task automatic send(input int n);
        repeat (n)
        begin
            @(negedge clock);
            sample_valid = 1'b1;
            sample_x = 16'($urandom);
            sample_y = 16'($urandom);
            sample_z = 16'($urandom);
            sent.push_back({sample_z, sample_y, sample_x});
        end
        @(negedge clock);
        sample_valid = 1'b0;
    endtask : send

    task automatic pulse(input logic p);
        @(negedge clock);
        first_irq_pin = !p;
        second_irq_pin = p;
        repeat (2) @(negedge clock);
        first_irq_pin = 1'b0;
        second_irq_pin = 1'b0;
        repeat (2) @(negedge clock);
    endtask : pulse

    // bypass empties the store and leaves the output entry unread-free
    task automatic clean();
        wr(8'h00);
        sent.delete();
        send(2);
        burst(1);
        rd(ACSF_ADDR_STAT, 8'h00);
    endtask : clean

    initial
    begin
        #400000;
        n_errors++;
        $display("watchdog expired");
        close_out();
    end

    initial
    begin
        void'($urandom(7));
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        rd(ACSF_ADDR_STAT, 8'h00);
        rd(ACSF_ADDR_CTRL, ACSF_CTRL_RESET);
        rd(8'h40, 8'h00);
        chk("watermark_flag", 8'(watermark_flag), 8'h00);
        chk("data_ready_flag", 8'(data_ready_flag), 8'h00);
        wr(8'h00);
        repeat (2) @(negedge clock);
        chk("watermark_flag", 8'(watermark_flag), 8'h01);
        $display("test reset done");
        wr(8'h44);
        sent.delete();
        send(40);
        rd(ACSF_ADDR_STAT, 8'h20);
        chk("overrun_flag", 8'(overrun_flag), 8'h01);
        chk("watermark_flag", 8'(watermark_flag), 8'h01);
        chk("data_ready_flag", 8'(data_ready_flag), 8'h01);
        burst(0);
        burst(1);
        rd(ACSF_ADDR_STAT, 8'h1e);
        chk("overrun_flag", 8'(overrun_flag), 8'h00);
        chk("data_ready_flag", 8'(data_ready_flag), 8'h00);
        $display("test collect done");
        clean();
        wr(8'h90);
        sent.delete();
        send(40);
        rd(ACSF_ADDR_STAT, 8'h20);
        chk("overrun_flag", 8'(overrun_flag), 8'h01);
        burst(0);
        burst(8);
        sleep_mode = 1'b1;
        send(3);
        sleep_mode = 1'b0;
        rd(ACSF_ADDR_STAT, 8'h1e);
        chk("data_ready_flag", 8'(data_ready_flag), 8'h00);
        $display("test stream done");
        clean();
        wr(8'hc3);
        sent.delete();
        send(10);
        rd(ACSF_ADDR_STAT, 8'h03);
        pulse(1'b1);
        rd(ACSF_ADDR_STAT, 8'h03);
        pulse(1'b0);
        rd(ACSF_ADDR_STAT, 8'h83);
        send(40);
        rd(ACSF_ADDR_STAT, 8'ha0);
        burst(0);
        burst(7);
        wr(8'he3);
        chk("capture_event_flag", 8'(capture_event_flag), 8'h00);
        pulse(1'b0);
        chk("capture_event_flag", 8'(capture_event_flag), 8'h00);
        pulse(1'b1);
        chk("capture_event_flag", 8'(capture_event_flag), 8'h01);
        $display("test trigger done");
        // mid-run reset with the capture flag set and samples stored
        rst_b = 1'b0;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        chk("capture_event_flag", 8'(capture_event_flag), 8'h00);
        rd(ACSF_ADDR_STAT, 8'h00);
        rd(ACSF_ADDR_CTRL, ACSF_CTRL_RESET);
        chk("watermark_flag", 8'(watermark_flag), 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule : tb_acsf_queue
